// ---- hdl/ncfh_map.svh ----
`ifndef NCFH_MAP_SVH
`define NCFH_MAP_SVH

// Register byte offsets on the Wishbone slave.
`define NCFH_REG_CTRL      8'h00
`define NCFH_REG_STATUS    8'h04
`define NCFH_REG_COUNT     8'h08
`define NCFH_REG_LAST_CMD  8'h0c
`define NCFH_REG_LAST_PAY  8'h10

// Control register fields and reset value.
`define NCFH_CTRL_ADDR_LSB 0
`define NCFH_CTRL_EN_BIT   16
`define NCFH_CTRL_RST      32'h0001_0001

// Status register fields.
`define NCFH_ST_BUSY_BIT   0
`define NCFH_ST_ASYNC_BIT  1
`define NCFH_ST_RESP_BIT   2
`define NCFH_ST_DROP_BIT   3
`define NCFH_ST_UNK_BIT    4

// Frame geometry: 80 bits in three 32-bit words.
`define NCFH_FRAME_BITS    80
`define NCFH_WORD_BITS     32
`define NCFH_FRAME_WORDS   2'd3

// Command identifier fields.
`define NCFH_ID_FLAG_BIT   15
`define NCFH_ID_CODE_MSB   14

// Address fields.
`define NCFH_AD_DB_LSB     0
`define NCFH_AD_DU_LSB     3
`define NCFH_AD_MB_LSB     6
`define NCFH_AD_DUC_BIT    9
`define NCFH_AD_CUC_BIT    10
`define NCFH_AD_COMBINED_COINCIDENCE_CONTROLLER_FLAG_BIT   11
`define NCFH_AD_MBC_BIT    12
`define NCFH_AD_HOST_BIT   14
`define NCFH_AD_BCAST_BIT  15

// Command codes (low fifteen bits of the identifier).
`define NCFH_CMD_PING      15'h0001
`define NCFH_CMD_MODE      15'h0003
`define NCFH_CMD_SCOPE     15'h0005
`define NCFH_CMD_TRIGMASK  15'h0009
`define NCFH_CMD_TDC       15'h0101
`define NCFH_CMD_THRESH    15'h0106

// Time digitiser control payloads.
`define NCFH_TDC_P_RESET   32'h0000_0080
`define NCFH_TDC_P_CAL     32'h0000_0002
`define NCFH_TDC_P_NORMAL  32'h0000_0004

// Power-up defaults of the configurable components.
`define NCFH_DEF_MODE      32'h0000_0000
`define NCFH_DEF_SCOPE     32'h0200_0100
`define NCFH_DEF_TRIGMASK  32'hffff_ffff
`define NCFH_DEF_THRESH    32'h0000_0000

`endif

// ---- hdl/ncfh_node.sv ----
`timescale 1ns/10ps
`include "ncfh_map.svh"
// What this block does
// - Commands and responses move as 32-bit serial words.
// - Parent writes command, later reads child response.
// - Frame: id, source, destination, 32-bit payload.
// - Function decoded from identifier bits 14 to 0.
// - Responses carry identifier bit 15 set.
// - Busy non-blocking child ignores other commands.
// - Destination marks receiver; shared address layout.
// - Address holds board, unit, multiplexer numbers.
// - Address bits 9-12 flag controller kinds.
// - Bit 14 flags host; bit 13 unused.
// - Destination bit 15 broadcasts; matching board responds.
// - Configurable parts take defaults at power-up.
// - Identifier 1 is a ping.
// - Identifier 3 selects acquisition mode.
// - Identifier 5 writes waveform capture settings.
// - Identifier 9 writes per-channel trigger mask.
// - Identifier 0x101 resets, calibrates, normalises digitiser.
// - Identifier 0x106 sets energy trigger threshold.
module ncfh_node #(
    parameter int EXEC_CYCLES = 16    // Cycles a command takes to execute.
) (
    input  wire logic                clk_sys_in,        // System clock, 25 MHz.
    input  wire logic                rst_n_in,          // Asynchronous reset, low.
    input  wire logic                wb_cyc_in,         // Wishbone cycle.
    input  wire logic                wb_stb_in,         // Wishbone strobe.
    input  wire logic                wb_we_in,          // Wishbone write enable.
    input  wire logic [7:0]          wb_adr_in,         // Wishbone byte address.
    input  wire logic [3:0]          wb_sel_in,         // Wishbone byte lanes.
    input  wire logic [31:0]         wb_dat_in,         // Wishbone write data.
    output logic      [31:0]         wb_dat_out,        // Wishbone read data.
    output logic                     wb_ack_out,        // Wishbone acknowledge.
    input  wire logic                spi_sclk_in,       // Link clock from parent.
    input  wire logic                spi_cs_n_in,       // Word select, low.
    input  wire logic                spi_mosi_in,       // Data from parent.
    output logic                     spi_miso_out,      // Data to parent.
    output logic                     spi_miso_oe_out,   // Drive enable of miso.
    output logic      [31:0]         acq_mode_out,      // Acquisition mode.
    output logic      [31:0]         scope_cfg_out,     // Waveform capture settings.
    output logic      [31:0]         trig_mask_out,     // Per-channel trigger mask.
    output logic      [31:0]         dac_threshold_out, // Energy threshold value.
    output ncfh_pkg::ncfh_tdc_t      tdc_state_out,     // Time digitiser state.
    output logic                     busy_out           // Command executing.
);
    import ncfh_pkg::*;

    // Elaboration check on the execution length.
    if (EXEC_CYCLES < 1 || EXEC_CYCLES > 65535) begin : g_chk
        $error("EXEC_CYCLES out of range");
    end

    localparam logic [15:0] EXEC_LAST = 16'(EXEC_CYCLES - 1); // Last count value.

    // Returns word i of an 80-bit frame, most significant part first.
    function automatic logic [31:0] frame_word(input logic [79:0] f, input logic [1:0] i);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (i)
            2'd0: w = f[79:48];
            2'd1: w = f[47:16];
            default: w = {f[15:0], 16'h0000}; // Padding is zero.
        endcase
        return w;
    endfunction

    // Synchronisers for the three link inputs.
    logic [1:0] sclk_sync;   // Link clock, two stages.
    logic [1:0] cs_sync;     // Select, two stages.
    logic [1:0] mosi_sync;   // Data, two stages.
    logic       sclk_prev;   // Last synchronised link clock.
    logic       cs_prev;     // Last synchronised select.

    // Edge strobes derived from the second synchroniser stage only.
    logic sclk_rise;  // Parent samples our data and we sample its data.
    logic sclk_fall;  // We move our next bit out.
    logic cs_fall;    // Word starts.
    logic cs_rise;    // Word ends.

    // Link shift state.
    logic [31:0] rx_shift;   // Incoming word.
    logic [31:0] tx_shift;   // Outgoing word.
    logic [5:0]  bit_count;  // Bits taken in the current word.
    logic [1:0]  word_idx;   // Position of the word in the frame.
    logic [79:0] rx_frame;   // Frame being assembled.
    logic        frame_done; // Pulse: a whole frame has arrived.

    // Command engine state.
    ncfh_exec_t  exec_state;   // Engine state.
    logic [15:0] exec_count;   // Cycles spent executing.
    logic [79:0] cmd_frame;    // Command being executed.
    logic        cmd_async;    // Running command is non-blocking.
    logic        cmd_reply;    // Running command wants a reply.
    logic [79:0] resp_frame;   // Response waiting to be read.
    logic        resp_valid;   // Response is pending.
    logic        resp_sending; // The current read frame carries the response.
    logic        dropped;      // Sticky: a command was ignored while busy.
    logic        unknown;      // Sticky: an unknown code arrived.
    logic [31:0] cmd_count;    // Commands accepted.

    // Register file.
    logic [31:0] ctrl;        // Own address and enable.
    logic [31:0] next_rdata;  // Read mux output.

    // Decoded fields of the arriving frame.
    logic [15:0] rx_id;
    logic [15:0] rx_src;
    logic [15:0] rx_dst;
    logic [15:0] own_addr;
    logic        rx_for_us;  // Accept the frame.
    logic        rx_reply;   // Reply to the frame.

    // Two-stage capture of the link pins.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_sync <= 2'b00;
            cs_sync   <= 2'b11;
            mosi_sync <= 2'b00;
            sclk_prev <= 1'b0;
            cs_prev   <= 1'b1;
        end else begin
            sclk_sync <= {sclk_sync[0], spi_sclk_in};
            cs_sync   <= {cs_sync[0], spi_cs_n_in};
            mosi_sync <= {mosi_sync[0], spi_mosi_in};
            sclk_prev <= sclk_sync[1];
            cs_prev   <= cs_sync[1];
        end
    end

    // Clock edges only count while the word is selected.
    assign sclk_rise = sclk_sync[1] & ~sclk_prev & ~cs_sync[1];
    assign sclk_fall = ~sclk_sync[1] & sclk_prev & ~cs_sync[1];
    assign cs_fall   = ~cs_sync[1] & cs_prev;
    assign cs_rise   = cs_sync[1] & ~cs_prev;

    // Receive side: shift bits in on rising link clock, MSB first.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_shift  <= 32'h0000_0000;
            bit_count <= 6'd0;
        end else if (cs_fall) begin
            bit_count <= 6'd0;
        end else if (sclk_rise && bit_count < 6'd32) begin
            rx_shift  <= {rx_shift[30:0], mosi_sync[1]};
            bit_count <= bit_count + 6'd1;
        end
    end

    // Word assembly: three full words make one frame; short words are dropped.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            word_idx   <= 2'd0;
            rx_frame   <= '0;
            frame_done <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            if (cs_rise && bit_count == 6'd32) begin
                unique case (word_idx)
                    2'd0: rx_frame[79:48] <= rx_shift;
                    2'd1: rx_frame[47:16] <= rx_shift;
                    default: rx_frame[15:0] <= rx_shift[31:16];
                endcase
                if (word_idx == `NCFH_FRAME_WORDS - 2'd1) begin
                    word_idx   <= 2'd0;
                    frame_done <= 1'b1;
                end else begin
                    word_idx <= word_idx + 2'd1;
                end
            end
        end
    end

    // Transmit side: load at word start, shift on falling link clock.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_shift <= 32'h0000_0000;
        end else if (cs_fall) begin
            // A pending response is read out; otherwise zeros go back.
            tx_shift <= resp_valid ? frame_word(resp_frame, word_idx) : 32'h0000_0000;
        end else if (sclk_fall) begin
            tx_shift <= {tx_shift[30:0], 1'b0};
        end
    end

    // Miso is driven only while a word is selected.
    assign spi_miso_out    = tx_shift[31];
    assign spi_miso_oe_out = ~cs_sync[1];

    // Field split of the arrived frame.
    assign rx_id    = rx_frame[79:64];
    assign rx_src   = rx_frame[63:48];
    assign rx_dst   = rx_frame[47:32];
    assign own_addr = ctrl[`NCFH_CTRL_ADDR_LSB +: 16];

    // Broadcast accepts everything; only the matching board replies.
    assign rx_reply  = (rx_dst[14:0] == own_addr[14:0]);
    assign rx_for_us = rx_dst[`NCFH_AD_BCAST_BIT] | rx_reply;

    // Command engine: accept, execute for EXEC_CYCLES, then reply.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            exec_state <= NCFH_EX_IDLE;
            exec_count <= 16'h0000;
            cmd_frame  <= '0;
            cmd_async  <= 1'b0;
            cmd_reply  <= 1'b0;
            dropped    <= 1'b0;
            cmd_count  <= 32'h0000_0000;
        end else begin
            // Software clears the sticky drop flag by writing status bit 3.
            if (wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[0]
                && wb_adr_in == `NCFH_REG_STATUS && wb_dat_in[`NCFH_ST_DROP_BIT]) begin
                dropped <= 1'b0;
            end
            // Poll frames (identifier zero) and foreign frames are ignored.
            // A frame refused while busy must not stall the running command.
            if (frame_done && rx_id != 16'h0000 && rx_for_us
                && ctrl[`NCFH_CTRL_EN_BIT] && exec_state != NCFH_EX_IDLE) begin
                dropped <= 1'b1;
            end
            if (frame_done && rx_id != 16'h0000 && rx_for_us
                && ctrl[`NCFH_CTRL_EN_BIT] && exec_state == NCFH_EX_IDLE) begin
                exec_state <= NCFH_EX_RUN;
                exec_count <= 16'h0000;
                cmd_frame  <= rx_frame;
                cmd_async  <= rx_id[`NCFH_ID_FLAG_BIT];
                cmd_reply  <= rx_reply;
                cmd_count  <= cmd_count + 32'h0000_0001;
            end else begin
                unique case (exec_state)
                    NCFH_EX_IDLE: begin
                    end
                    NCFH_EX_RUN: begin
                        if (exec_count == EXEC_LAST) begin
                            exec_state <= NCFH_EX_DONE;
                        end else begin
                            exec_count <= exec_count + 16'h0001;
                        end
                    end
                    NCFH_EX_DONE: begin
                        exec_state <= NCFH_EX_IDLE;
                    end
                endcase
            end
        end
    end

    assign busy_out = (exec_state != NCFH_EX_IDLE);

    // Configuration outputs, loaded with defaults at reset.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acq_mode_out      <= `NCFH_DEF_MODE;
            scope_cfg_out     <= `NCFH_DEF_SCOPE;
            trig_mask_out     <= `NCFH_DEF_TRIGMASK;
            dac_threshold_out <= `NCFH_DEF_THRESH;
            tdc_state_out     <= NCFH_TDC_NORMAL;
            unknown           <= 1'b0;
        end else begin
            // Software clears the unknown-code flag by writing status bit 4.
            if (wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[0]
                && wb_adr_in == `NCFH_REG_STATUS && wb_dat_in[`NCFH_ST_UNK_BIT]) begin
                unknown <= 1'b0;
            end
            // Effects apply when execution completes; set wins over clear.
            if (exec_state == NCFH_EX_DONE) begin
                unique case (cmd_frame[78:64])
                    `NCFH_CMD_PING: begin
                    end
                    `NCFH_CMD_MODE: acq_mode_out <= cmd_frame[31:0];
                    `NCFH_CMD_SCOPE: scope_cfg_out <= cmd_frame[31:0];
                    `NCFH_CMD_TRIGMASK: trig_mask_out <= cmd_frame[31:0];
                    `NCFH_CMD_THRESH: dac_threshold_out <= cmd_frame[31:0];
                    `NCFH_CMD_TDC: begin
                        if (cmd_frame[31:0] == `NCFH_TDC_P_RESET) begin
                            tdc_state_out <= NCFH_TDC_RESET;
                        end else if (cmd_frame[31:0] == `NCFH_TDC_P_CAL) begin
                            tdc_state_out <= NCFH_TDC_CAL;
                        end else if (cmd_frame[31:0] == `NCFH_TDC_P_NORMAL) begin
                            tdc_state_out <= NCFH_TDC_NORMAL;
                        end else begin
                            unknown <= 1'b1;
                        end
                    end
                    default: unknown <= 1'b1;
                endcase
            end
        end
    end

    // Response builder and delivery tracking.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            resp_frame   <= '0;
            resp_valid   <= 1'b0;
            resp_sending <= 1'b0;
        end else begin
            // Mark a read frame as carrying the response when its first word starts.
            if (cs_fall && word_idx == 2'd0) begin
                resp_sending <= resp_valid;
            end
            if (exec_state == NCFH_EX_DONE && cmd_reply) begin
                // Identifier echoed with bit 15 set, addresses swapped.
                resp_frame[79:64] <= {1'b1, cmd_frame[78:64]};
                resp_frame[63:48] <= cmd_frame[47:32] & 16'h7fff;
                resp_frame[47:32] <= cmd_frame[63:48];
                unique case (cmd_frame[78:64])
                    `NCFH_CMD_PING: resp_frame[31:0] <= {16'h0000, own_addr};
                    `NCFH_CMD_MODE,
                    `NCFH_CMD_SCOPE,
                    `NCFH_CMD_TRIGMASK,
                    `NCFH_CMD_TDC,
                    `NCFH_CMD_THRESH: resp_frame[31:0] <= cmd_frame[31:0];
                    default: resp_frame[31:0] <= 32'hffff_ffff;
                endcase
                resp_valid   <= 1'b1;
                resp_sending <= 1'b0;
            end else if (frame_done && resp_sending) begin
                // Third word of the response has been clocked out.
                resp_valid   <= 1'b0;
                resp_sending <= 1'b0;
            end
        end
    end

    // Control register, byte lanes 0 to 2 writable.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl <= `NCFH_CTRL_RST;
        end else if (wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out
                     && wb_adr_in == `NCFH_REG_CTRL) begin
            for (int b = 0; b < 3; b++) begin
                if (wb_sel_in[b]) begin
                    ctrl[b*8 +: 8] <= wb_dat_in[b*8 +: 8];
                end
            end
        end
    end

    // Read multiplexer; unmapped addresses read zero.
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (wb_adr_in)
            `NCFH_REG_CTRL:     next_rdata = {15'h0000, ctrl[16:0]};
            `NCFH_REG_STATUS:   next_rdata = {27'h0000000, unknown, dropped,
                                              resp_valid, cmd_async & busy_out,
                                              busy_out};
            `NCFH_REG_COUNT:    next_rdata = cmd_count;
            `NCFH_REG_LAST_CMD: next_rdata = cmd_frame[79:48];
            `NCFH_REG_LAST_PAY: next_rdata = cmd_frame[31:0];
            default:            next_rdata = 32'h0000_0000;
        endcase
    end

    // Wishbone answer: ack one cycle after the strobe, for one cycle.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
            if (wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_we_in) begin
                wb_dat_out <= next_rdata;
            end
        end
    end
endmodule

// ---- hdl/ncfh_pkg.sv ----
package ncfh_pkg;
    // Operating state of the high-resolution time digitiser.
    typedef enum logic [1:0] {
        NCFH_TDC_NORMAL,
        NCFH_TDC_RESET,
        NCFH_TDC_CAL
    } ncfh_tdc_t;

    // Execution state of the command engine.
    typedef enum logic [1:0] {
        NCFH_EX_IDLE,
        NCFH_EX_RUN,
        NCFH_EX_DONE
    } ncfh_exec_t;
endpackage

// ---- verif/ncfh_node_properties.sv ----
`timescale 1ns/10ps
module ncfh_node_properties #(
    parameter int EXEC_CYCLES = 16    // Cycles a command takes to execute.
) (
    input wire logic                clk_sys_in,
    input wire logic                rst_n_in,
    input wire logic                wb_cyc_in,
    input wire logic                wb_stb_in,
    input wire logic                wb_we_in,
    input wire logic [31:0]         wb_dat_out,
    input wire logic                wb_ack_out,
    input wire logic                spi_cs_n_in,
    input wire logic                spi_miso_oe_out,
    input wire logic [31:0]         acq_mode_out,
    input wire logic [31:0]         scope_cfg_out,
    input wire logic [31:0]         trig_mask_out,
    input wire logic [31:0]         dac_threshold_out,
    input wire ncfh_pkg::ncfh_tdc_t tdc_state_out,
    input wire logic                busy_out
);
    import ncfh_pkg::*;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    logic [15:0] busy_len;    // Length of the current busy stretch.
    // Count busy cycles so the full stretch can be checked when it ends.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_len <= 16'h0000;
        end else if (busy_out) begin
            busy_len <= busy_len + 16'h0001;
        end else begin
            busy_len <= 16'h0000;
        end
    end
    AST_ACK_NEXT: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("ack did not follow a request by one cycle");
    AST_ACK_DROP: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack stood longer than one cycle");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
        else $error("ack without a request");
    AST_RD_HOLD: assert property (!$stable(wb_dat_out) |-> wb_ack_out && !$past(wb_we_in))
        else $error("read data changed outside a read answer");
    AST_OE_ON: assert property (!spi_cs_n_in [*5] |-> spi_miso_oe_out)
        else $error("miso not driven while selected");
    AST_OE_OFF: assert property (spi_cs_n_in [*5] |-> !spi_miso_oe_out)
        else $error("miso driven while deselected");
    AST_BUSY_LEN: assert property ($fell(busy_out) |-> busy_len == 16'(EXEC_CYCLES + 1))
        else $error("busy stretch has the wrong length");
    AST_CFG_STEADY: assert property (!$stable({acq_mode_out, scope_cfg_out,
        trig_mask_out, dac_threshold_out, tdc_state_out})
        |-> $past(busy_out) || $past(busy_out, 2))
        else $error("configuration changed with no command executing");
    COV_BUSY: cover property ($rose(busy_out));
    COV_CAL: cover property (tdc_state_out == NCFH_TDC_CAL);
    COV_READ: cover property (wb_ack_out && !wb_we_in);
endmodule
bind ncfh_node ncfh_node_properties #(.EXEC_CYCLES(EXEC_CYCLES)) u_props (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .spi_cs_n_in(spi_cs_n_in), .spi_miso_oe_out(spi_miso_oe_out),
    .acq_mode_out(acq_mode_out), .scope_cfg_out(scope_cfg_out),
    .trig_mask_out(trig_mask_out), .dac_threshold_out(dac_threshold_out),
    .tdc_state_out(tdc_state_out), .busy_out(busy_out));

// ---- verif/ncfh_parent_model.sv ----
`timescale 1ns/10ps
module ncfh_parent_model (
    output logic      sclk_out,    // Link clock, still between words.
    output logic      cs_n_out,    // Word select, low.
    output logic      mosi_out,    // Data to the child.
    input  wire logic miso_in      // Data from the child.
);
    // The link idles deselected with its clock low.
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // One 32-bit word each way, MSB first, 160 ns half period.
    task automatic xfer(input logic [31:0] w, output logic [31:0] r);
        #7;
        cs_n_out = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            mosi_out = w[i];
            #160;
            sclk_out = 1'b1;
            r[i] = miso_in;
            #160;
            sclk_out = 1'b0;
        end
        #160;
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out;    // Released data line shows no stale bit.
        #320;
    endtask
endmodule

// ---- verif/tb_ncfh_node.sv ----
`timescale 1ns/10ps
module tb_ncfh_node;
    import ncfh_pkg::*;
    localparam int EXEC = 1000;    // Long enough for a second frame to land while busy.
    logic       clk_sys_in, rst_n_in, cyc, stb, we, ack, sclk, cs_n, mosi, miso, oe, busy;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, acq, scope, trig, dac, q, seed;
    logic [15:0] dst;
    logic [79:0] rsp;
    ncfh_tdc_t   tdc;
    int          num_errors, checks;
    logic [15:0] ids [8] = '{16'h3, 16'h5, 16'h9, 16'h106, 16'h101, 16'h101, 16'h101, 16'h1};
    logic [31:0] pays [8];
    ncfh_node #(.EXEC_CYCLES(EXEC)) dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
        .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .spi_sclk_in(sclk),
        .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(oe),
        .acq_mode_out(acq), .scope_cfg_out(scope), .trig_mask_out(trig),
        .dac_threshold_out(dac), .tdc_state_out(tdc), .busy_out(busy));
    ncfh_parent_model u_par (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));
    // Free-running system clock.
    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    // Prints the counts and the verdict, then ends the run.
    task results;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Compares one value and reports a difference.
    task check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask
    // Next value of the xorshift generator.
    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Digitiser state that a control payload should leave behind.
    function logic [31:0] exp_tdc(input logic [31:0] p);
        return (p == 32'h80) ? 32'h1 : ((p == 32'h2) ? 32'h2 : 32'h0);
    endfunction
    // Classic single Wishbone cycle, held until ack is sampled.
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_sys_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk_sys_in);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Sends one command frame from the host as three words.
    task send_frame(input logic [15:0] id, input logic [15:0] d, input logic [31:0] p);
        logic [31:0] r;
        u_par.xfer({id, 16'h4000}, r);
        u_par.xfer({d, p[31:16]}, r);
        u_par.xfer({p[15:0], 16'h0000}, r);
    endtask
    // Reads the three response words back with zeros on the data line.
    task get_rsp(output logic [79:0] f);
        logic [31:0] a, b, c;
        u_par.xfer(32'h0, a);
        u_par.xfer(32'h0, b);
        u_par.xfer(32'h0, c);
        f = {a, b, c[31:16]};
    endtask
    // Watchdog on the whole run.
    initial begin
        #2400000;
        num_errors++;
        results();
    end
    // Main sequence.
    initial begin
        {cyc, stb, we, adr, sel, wdat, rst_n_in} = '0;
        num_errors = 0;
        checks = 0;
        seed = 32'h6f84;
        repeat (6) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        check(scope, 32'h0200_0100);
        check(trig, 32'hffff_ffff);
        check(acq, 32'h0);
        check(dac, 32'h0);
        check({29'h0, tdc, busy}, 32'h0);
        wb(1'b0, 8'h00, 32'h0, q);
        check(q, 32'h0001_0001);
        wb(1'b1, 8'h00, 32'h0001_0003, q);
        wb(1'b0, 8'h00, 32'h0, q);
        check(q, 32'h0001_0003);
        wb(1'b0, 8'h3c, 32'h0, q);
        check(q, 32'h0);
        seed = xs(seed);
        pays = '{32'h1, 32'h0200_0100, seed, xs(seed), 32'h80, 32'h2, 32'h4, 32'h0};
        for (int k = 0; k < 8; k++) begin
            dst = k[0] ? 16'h0003 : 16'h8003;
            send_frame(ids[k], dst, pays[k]);
            repeat (EXEC + 10) @(posedge clk_sys_in);
            case (ids[k])
                16'h3: check(acq, pays[k]);
                16'h5: check(scope, pays[k]);
                16'h9: check(trig, pays[k]);
                16'h106: check(dac, pays[k]);
                16'h101: check({30'h0, tdc}, exp_tdc(pays[k]));
                default: check(acq, 32'h1);
            endcase
            get_rsp(rsp);
            check(rsp[79:48], {ids[k] | 16'h8000, dst & 16'h7fff});
            check({16'h0, rsp[47:32]}, 32'h4000);
            check(rsp[31:0], (ids[k] == 16'h1) ? 32'h3 : pays[k]);
        end
        send_frame(16'h3, 16'h0005, 32'h7);
        repeat (EXEC + 10) @(posedge clk_sys_in);
        check(acq, 32'h1);
        send_frame(16'h8003, 16'h0003, 32'h5);
        check({31'h0, busy}, 32'h1);
        send_frame(16'h3, 16'h0003, 32'h9);
        repeat (EXEC + 10) @(posedge clk_sys_in);
        check(acq, 32'h5);
        wb(1'b0, 8'h04, 32'h0, q);
        check(q & 32'h8, 32'h8);
        wb(1'b1, 8'h04, 32'h8, q);
        wb(1'b0, 8'h04, 32'h0, q);
        check(q & 32'h8, 32'h0);
        send_frame(16'h7, 16'h0003, 32'h0);
        repeat (EXEC + 10) @(posedge clk_sys_in);
        wb(1'b0, 8'h04, 32'h0, q);
        check(q & 32'h10, 32'h10);
        get_rsp(rsp);
        check(rsp[31:0], 32'hffff_ffff);
        results();
    end
endmodule
